// ===== common/sector_guard_pkg.sv
// constants shared by the sector write guard logic
package sector_guard_pkg;

  // ********************************************************
  // command opcodes
  // ********************************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_SCHEME_SELECT = 8'h68;
  localparam logic [7:0] OP_PROGRAM_LOCK = 8'h2c;
  localparam logic [7:0] OP_READ_LOCK = 8'h2d;
  localparam logic [7:0] OP_LATCH_CLEAR = 8'ha6;
  localparam logic [7:0] OP_READ_LATCH = 8'ha7;
  localparam logic [7:0] OP_SET_NV_GUARD = 8'he3;
  localparam logic [7:0] OP_ERASE_NV_GUARD = 8'he4;
  localparam logic [7:0] OP_READ_NV_GUARD = 8'he2;
  localparam logic [7:0] OP_WRITE_VOL_GUARD = 8'he1;
  localparam logic [7:0] OP_READ_VOL_GUARD = 8'he0;
  localparam logic [7:0] OP_GANG_LOCK = 8'h7e;
  localparam logic [7:0] OP_GANG_UNLOCK = 8'h98;
  localparam logic [7:0] OP_PASSWORD_UNLOCK = 8'h29;

  // ********************************************************
  // frame lengths in serial clock edges
  // ********************************************************
  localparam int CNT_W = 7;
  localparam logic [6:0] CNT_MAX = 7'h7f;
  localparam logic [6:0] LEN_OP = 7'h08;
  localparam logic [6:0] LEN_LOCK = 7'h18;
  localparam logic [6:0] LEN_ADDR = 7'h28;
  localparam logic [6:0] LEN_ADDR_DATA = 7'h30;
  localparam logic [6:0] LEN_PASSWORD = 7'h48;
  localparam int FRAME_ADDR_W = 32;
  localparam int PASSWORD_W = 64;

  // ********************************************************
  // register layout and reset values
  // ********************************************************
  localparam int LOCK_W = 16;
  localparam int LOCK_SOLID_BIT = 1;
  localparam int LOCK_PASS_BIT = 2;
  localparam logic [15:0] LOCK_FACTORY = 16'hffff;
  localparam int LATCH_W = 8;
  localparam logic [6:0] LATCH_RSVD = 7'h00;
  localparam logic [7:0] GUARD_SET = 8'hff;
  localparam logic [7:0] GUARD_CLEAR = 8'h00;

  // ********************************************************
  // region geometry
  // ********************************************************
  localparam int SECT_LSB = 12;
  localparam int BLK_LSB = 16;
  localparam int SUB_SECT = 16;

endpackage : sector_guard_pkg

// ===== src/sector_write_guard_logic.sv
// sector write guard logic: lock modes, guard latch and guard bits
//
// Functional notes
// - 16-bit one-time lock, bits 2:1 pick mode
// - clearing lock bit 1 fixes solid mode
// - clearing lock bit 2 fixes password mode
// - clearing both aborts, sets program-fail flag
// - after one bit cleared, other stays
// - guard latch is bit 0, read back
// - latch resets by mode; reserved bits zero
// - latch clear writes zero; only reset or valid password restores
// - password mode: valid password sets latch
// - one nonvolatile bit per region, factory zero
// - protected region inhibits program and erase
// - set one nonvolatile bit; erase clears all
// - latch zero ignores nonvolatile bit changes
// - nonvolatile read gives 00h or FFh
// - volatile bit per region, resets to one
// - unprotected only when both bits zero
// - volatile write, gang unlock, gang lock
// - volatile read gives 00h or FFh
// - gang opcodes 7Eh/98h need scheme bit
// - gang frame must end on byte boundary
// - guard scheme only while scheme bit set
// - write protect pin low protects everything
// - program-fail flag volatile, set on protection
`timescale 1ns/1ps

module sector_write_guard_logic
  import sector_guard_pkg::*;
#(
  parameter int ADDR_W = 24
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic si_in,
  output logic so_out,
  output logic so_oe_out,
  input wire logic wp_n_in,
  input wire logic hw_reset_n_in,
  input wire logic [PASSWORD_W-1:0] password_in,
  input wire logic chk_valid_in,
  input wire logic chk_prog_in,
  input wire logic [ADDR_W-1:0] chk_addr_in,
  input wire logic prog_fail_in,
  input wire logic prog_ok_in,
  output logic chk_ack_out,
  output logic chk_prot_out,
  output logic write_enable_latch_out,
  output logic scheme_select_bit_out,
  output logic guard_bit_latch_out,
  output logic prog_fail_out
);

  // ********************************************************
  // geometry
  // ********************************************************
  localparam int NBLK = 2 ** (ADDR_W - BLK_LSB);
  localparam int NREG = NBLK - 2 + 2 * SUB_SECT;
  localparam int IDX_W = $clog2(NREG);

  // address to region: edge blocks split into sectors
  function automatic logic [IDX_W-1:0] region_of(
    input logic [ADDR_W-1:0] a);
    int blk;
    int sec;
    int r;
    blk = int'(a[ADDR_W-1:BLK_LSB]);
    sec = int'(a[BLK_LSB-1:SECT_LSB]);
    if (blk == 0) begin
      r = sec;
    end else if (blk == NBLK - 1) begin
      r = SUB_SECT + NBLK - 2 + sec;
    end else begin
      r = SUB_SECT - 1 + blk;
    end
    return IDX_W'(r);
  endfunction : region_of

  // clock domain state, declared up front
  logic in_frame;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [7:0] op;
  logic [PASSWORD_W-1:0] sh;
  logic [FRAME_ADDR_W-1:0] addr_l;
  logic so_q;
  logic cs_s1, cs_s2, cs_s3;
  logic wp_s1, wp_s2;
  logic hr_s1, hr_s2;
  logic write_enable_latch;
  logic scheme;
  logic [LOCK_W-1:0] lock_q;
  logic latch;
  logic pfail;
  logic [NREG-1:0] nv;
  logic [NREG-1:0] vol;

  // ********************************************************
  // link side: serial clock domain
  // ********************************************************

  // frame marker, cleared while chip select is high
  wire frame_rst_n = rst_n_in & ~cs_n_in;

  always_ff @(posedge sclk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // first edge of a frame restarts the count; saturate
  assign next_cnt = !in_frame ? 7'h01 :
                    (cnt == CNT_MAX) ? cnt : cnt + 7'h01;

  // frame fields stay put while the serial clock stands still,
  // which is what lets the core domain read them after cs rises
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= '0;
      sh <= '0;
    end else begin
      cnt <= next_cnt;
      sh <= {sh[PASSWORD_W-2:0], si_in};
    end
  end

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op <= '0;
    end else if (next_cnt == LEN_OP) begin
      op <= {sh[6:0], si_in};
    end
  end

  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_l <= '0;
    end else if (next_cnt == LEN_ADDR) begin
      addr_l <= {sh[FRAME_ADDR_W-2:0], si_in};
    end
  end

  // read answers; guard state only changes between frames, so
  // this quasi-static look-up is safe while the frame runs
  wire [IDX_W-1:0] rd_idx = region_of(addr_l[ADDR_W-1:0]);
  wire rd_guard = (op == OP_READ_NV_GUARD) ||
                  (op == OP_READ_VOL_GUARD);
  wire rd_short = (op == OP_READ_LOCK) ||
                  (op == OP_READ_LATCH);
  wire [CNT_W-1:0] rd_start = rd_guard ? LEN_ADDR : LEN_OP;
  wire rd_act = scheme && (rd_guard || rd_short) &&
                in_frame && (cnt >= rd_start);
  wire [3:0] bit_idx = 4'(cnt - rd_start);
  wire [7:0] latch_byte = {LATCH_RSVD, latch};
  wire [7:0] nv_byte = nv[rd_idx] ? GUARD_SET : GUARD_CLEAR;
  wire [7:0] vol_byte = vol[rd_idx] ? GUARD_SET : GUARD_CLEAR;
  wire [15:0] resp16 =
    (op == OP_READ_LOCK) ? lock_q :
    (op == OP_READ_LATCH) ? {latch_byte, latch_byte} :
    (op == OP_READ_NV_GUARD) ? {nv_byte, nv_byte} :
    {vol_byte, vol_byte};

  // shift out on the falling edge, most significant bit first
  always_ff @(negedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      so_q <= 1'b0;
    end else begin
      so_q <= resp16[4'hf - bit_idx];
    end
  end

  assign so_out = so_q;
  assign so_oe_out = rd_act && !cs_n_in;

  // ********************************************************
  // core side: pin synchronisers
  // ********************************************************

  // every pin passes two flops; cs_s3 only feeds the edge test
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      {cs_s1, cs_s2, cs_s3} <= 3'h7;
      {wp_s1, wp_s2} <= 2'h3;
      {hr_s1, hr_s2} <= 2'h3;
    end else if (ce_in) begin
      {cs_s1, cs_s2, cs_s3} <= {cs_n_in, cs_s1, cs_s2};
      {wp_s1, wp_s2} <= {wp_n_in, wp_s1};
      {hr_s1, hr_s2} <= {hw_reset_n_in, hr_s1};
    end
  end

  // ********************************************************
  // command decode
  // ********************************************************
  wire exec = ce_in && cs_s2 && !cs_s3;
  wire vol_rst = ce_in && !hr_s2;
  wire asp_wel = write_enable_latch && scheme;
  wire pass_mode = !lock_q[LOCK_PASS_BIT];
  wire solid_fixed = !lock_q[LOCK_SOLID_BIT];
  wire mode_fixed = pass_mode || solid_fixed;
  wire [7:0] d8 = sh[7:0];
  wire [15:0] d16 = sh[15:0];
  wire [IDX_W-1:0] cmd_idx = region_of(addr_l[ADDR_W-1:0]);

  wire needs_wel = (op == OP_SCHEME_SELECT) ||
                   (op == OP_PROGRAM_LOCK) ||
                   (op == OP_LATCH_CLEAR) ||
                   (op == OP_SET_NV_GUARD) ||
                   (op == OP_ERASE_NV_GUARD) ||
                   (op == OP_WRITE_VOL_GUARD) ||
                   (op == OP_GANG_LOCK) ||
                   (op == OP_GANG_UNLOCK) ||
                   (op == OP_PASSWORD_UNLOCK);

  wire do_write_enable_cmd = exec && (op == OP_WRITE_ENABLE) &&
                 (cnt == LEN_OP);
  wire do_sel = exec && write_enable_latch && (op == OP_SCHEME_SELECT) &&
                (cnt == LEN_OP);
  wire do_lock = exec && asp_wel && (op == OP_PROGRAM_LOCK) &&
                 (cnt == LEN_LOCK);
  wire lock_both = !d16[LOCK_SOLID_BIT] && !d16[LOCK_PASS_BIT];
  wire lock_bad = do_lock && lock_both;
  wire lock_ok = do_lock && !lock_both;
  wire do_lclr = exec && asp_wel && (op == OP_LATCH_CLEAR) &&
                 (cnt == LEN_OP);
  wire do_unl = exec && asp_wel && pass_mode &&
                (op == OP_PASSWORD_UNLOCK) &&
                (cnt == LEN_PASSWORD);
  wire pw_ok = (sh == password_in);
  wire unl_ok = do_unl && pw_ok;
  wire unl_bad = do_unl && !pw_ok;
  wire do_setnv = exec && asp_wel && latch &&
                  (op == OP_SET_NV_GUARD) && (cnt == LEN_ADDR);
  wire do_ersnv = exec && asp_wel && latch &&
                  (op == OP_ERASE_NV_GUARD) && (cnt == LEN_OP);
  wire do_wvol = exec && asp_wel &&
                 (op == OP_WRITE_VOL_GUARD) &&
                 (cnt == LEN_ADDR_DATA);
  // a gang opcode only counts when cs rose right after 8 bits
  wire do_glk = exec && asp_wel && (op == OP_GANG_LOCK) &&
                (cnt == LEN_OP);
  wire do_gul = exec && asp_wel && (op == OP_GANG_UNLOCK) &&
                (cnt == LEN_OP);

  // once a mode is fixed its two bits never move again
  wire [LOCK_W-1:0] lock_prog = lock_q & d16;
  wire [LOCK_W-1:0] next_lock = mode_fixed ?
    {lock_prog[LOCK_W-1:LOCK_PASS_BIT+1],
     lock_q[LOCK_PASS_BIT:LOCK_SOLID_BIT],
     lock_prog[LOCK_SOLID_BIT-1:0]} :
    lock_prog;

  // ********************************************************
  // protection check for program and erase
  // ********************************************************
  wire [IDX_W-1:0] chk_idx = region_of(chk_addr_in);
  wire prot_now = scheme && (!wp_s2 ||
                  nv[chk_idx] || vol[chk_idx]);
  wire pfail_set = lock_bad || unl_bad ||
                   (ce_in && chk_valid_in && chk_prog_in &&
                    prot_now) ||
                   (ce_in && prog_fail_in);

  // ********************************************************
  // state registers
  // ********************************************************

  // write enable: any guarded command consumes it
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_enable_latch <= 1'b0;
    end else if (vol_rst) begin
      write_enable_latch <= 1'b0;
    end else if (do_write_enable_cmd) begin
      write_enable_latch <= 1'b1;
    end else if (exec && needs_wel) begin
      write_enable_latch <= 1'b0;
    end
  end

  // one-time bits; power-on reset models the factory state
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scheme <= 1'b0;
      lock_q <= LOCK_FACTORY;
    end else begin
      if (do_sel) begin
        scheme <= 1'b1;
      end
      if (lock_ok) begin
        lock_q <= next_lock;
      end
    end
  end

  // guard latch: no command can raise it in solid mode
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch <= 1'b1;
    end else if (vol_rst) begin
      latch <= !pass_mode;
    end else if (do_lclr) begin
      latch <= 1'b0;
    end else if (unl_ok) begin
      latch <= 1'b1;
    end
  end

  // nonvolatile guards: hardware reset leaves them alone
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nv <= '0;
    end else if (do_ersnv) begin
      nv <= '0;
    end else if (do_setnv) begin
      nv[cmd_idx] <= 1'b1;
    end
  end

  // volatile guards: any nonzero data byte sets the bit
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vol <= '1;
    end else if (vol_rst || do_glk) begin
      vol <= '1;
    end else if (do_gul) begin
      vol <= '0;
    end else if (do_wvol) begin
      vol[cmd_idx] <= |d8;
    end
  end

  // program-fail flag: a set in the clearing cycle wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pfail <= 1'b0;
    end else if (vol_rst) begin
      pfail <= 1'b0;
    end else if (pfail_set) begin
      pfail <= 1'b1;
    end else if (ce_in && prog_ok_in) begin
      pfail <= 1'b0;
    end
  end

  // check answer, one cycle after the request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      chk_ack_out <= 1'b0;
      chk_prot_out <= 1'b0;
    end else if (ce_in) begin
      chk_ack_out <= chk_valid_in;
      if (chk_valid_in) begin
        chk_prot_out <= prot_now;
      end
    end
  end

  assign write_enable_latch_out = write_enable_latch;
  assign scheme_select_bit_out = scheme;
  assign guard_bit_latch_out = latch;
  assign prog_fail_out = pfail;

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);

  property p_gang_lock;
    (do_glk && hr_s2) |=> (&vol);
  endproperty
  a_gang_lock: assert property (p_gang_lock)
    else $error("gang lock left a volatile guard clear");

  property p_gang_unlock;
    (exec && write_enable_latch && scheme && (op == OP_GANG_UNLOCK) &&
     (cnt == LEN_OP) && hr_s2) |=> (vol == '0);
  endproperty
  a_gang_unlock: assert property (p_gang_unlock)
    else $error("gang unlock left a volatile guard set");

  property p_gang_boundary;
    (exec && (op == OP_GANG_UNLOCK) && (cnt != LEN_OP) &&
     hr_s2) |=> $stable(vol);
  endproperty
  a_gang_boundary: assert property (p_gang_boundary)
    else $error("gang command ran off a byte boundary");

  property p_both_abort;
    (lock_bad && hr_s2) |=> (pfail && $stable(lock_q));
  endproperty
  a_both_abort: assert property (p_both_abort)
    else $error("double lock clear not aborted");

  property p_mode_otp;
    mode_fixed |=> $stable(lock_q[LOCK_PASS_BIT:LOCK_SOLID_BIT]);
  endproperty
  a_mode_otp: assert property (p_mode_otp)
    else $error("fixed protection mode changed");

  property p_latch_rise;
    $rose(latch) |-> ($past(unl_ok) || $past(vol_rst));
  endproperty
  a_latch_rise: assert property (p_latch_rise)
    else $error("guard latch raised without cause");

  property p_nv_locked;
    (exec && !latch) |=> $stable(nv);
  endproperty
  a_nv_locked: assert property (p_nv_locked)
    else $error("nonvolatile guard changed while locked");

  property p_wp_pin;
    (ce_in && chk_valid_in && scheme && !wp_s2) |=>
      (chk_ack_out && chk_prot_out);
  endproperty
  a_wp_pin: assert property (p_wp_pin)
    else $error("write protect pin did not protect");

  property p_pfail;
    (ce_in && chk_valid_in && chk_prog_in && prot_now &&
     hr_s2) |=> pfail ##1 (pfail || $past(prog_ok_in) || !$past(hr_s2));
  endproperty
  a_pfail: assert property (p_pfail)
    else $error("protected program did not flag failure");

  property p_unprot;
    (ce_in && chk_valid_in && scheme && wp_s2 &&
     !nv[chk_idx] && !vol[chk_idx]) |=> !chk_prot_out;
  endproperty
  a_unprot: assert property (p_unprot)
    else $error("region with both guards clear protected");

  c_gang_unlock: cover property (do_gul);
  c_pass_mode: cover property (lock_ok && !d16[LOCK_PASS_BIT]);
  c_unlock_ok: cover property (unl_ok);
  c_protected: cover property (chk_ack_out && chk_prot_out);

endmodule : sector_write_guard_logic

// ===== testbench/host_serial_model.sv
// host controller model that drives frames onto the serial link
`timescale 1ns/1ps

module host_serial_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic si_out,
  input wire logic so_in,
  input wire logic so_oe_in
);
  // ********************************************************
  // frame transfer
  // ********************************************************

  // link idles deselected with the clock standing low
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end

  // n bits out msb first, then nrd bits in; clock runs inside frames only
  task automatic xfer(input logic [71:0] d, input int n, input int nrd,
                      output logic [15:0] rd);
    rd = 16'h0000;
    #1.3;
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_out = d[i];
      #80 sclk_out = 1'b1;
      #80 sclk_out = 1'b0;
    end
    si_out = ~si_out; // released data line must not hold a stale bit
    for (int i = 0; i < nrd; i++) begin
      #80 sclk_out = 1'b1;
      rd = {rd[14:0], so_oe_in ? so_in : ~so_in}; // released line flips
      #80 sclk_out = 1'b0;
    end
    #80 cs_n_out = 1'b1; // deselect 80 ns after the last clock edge
    si_out = ~si_out;
    #120;
  endtask : xfer
endmodule : host_serial_model

// ===== testbench/testbench.sv
// self-checking bench for the sector write guard logic
`timescale 1ns/1ps

module testbench;
  import sector_guard_pkg::*;

  localparam int NREG = 286;
  logic clk_in = 1'b0;
  logic rst_n_in, ce_in, wp_n_in, hw_reset_n_in;
  logic chk_valid_in, chk_prog_in, prog_fail_in, prog_ok_in;
  logic [23:0] chk_addr_in, a, a3;
  logic [63:0] password_in;
  wire sclk_in, cs_n_in, si_in, so_out, so_oe_out;
  wire chk_ack_out, chk_prot_out, write_enable_latch_out;
  wire scheme_select_bit_out, guard_bit_latch_out, prog_fail_out;
  logic [15:0] lock_m, rd;
  bit wel_m, scheme_m, latch_m, fail_m;
  bit nv_m [NREG];
  bit vol_m [NREG];
  int num_errors = 0;
  int checked = 0;
  logic [31:0] lfsr = 32'h0000002a;

  sector_write_guard_logic sector_write_guard_logic_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(ce_in),
    .sclk_in(sclk_in), .cs_n_in(cs_n_in), .si_in(si_in),
    .so_out(so_out), .so_oe_out(so_oe_out), .wp_n_in(wp_n_in),
    .hw_reset_n_in(hw_reset_n_in), .password_in(password_in),
    .chk_valid_in(chk_valid_in), .chk_prog_in(chk_prog_in),
    .chk_addr_in(chk_addr_in), .prog_fail_in(prog_fail_in),
    .prog_ok_in(prog_ok_in), .chk_ack_out(chk_ack_out),
    .chk_prot_out(chk_prot_out),
    .write_enable_latch_out(write_enable_latch_out),
    .scheme_select_bit_out(scheme_select_bit_out),
    .guard_bit_latch_out(guard_bit_latch_out),
    .prog_fail_out(prog_fail_out));

  host_serial_model host_serial_model_i (
    .sclk_out(sclk_in), .cs_n_out(cs_n_in), .si_out(si_in),
    .so_in(so_out), .so_oe_in(so_oe_out));

  // core clock, 4 ns period
  always #2 clk_in = ~clk_in;

  // ********************************************************
  // reference model and helpers
  // ********************************************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // edge 64 KB hold 16 sectors each, the rest one region per block
  function automatic int region(input logic [23:0] x);
    if (x[23:16] == 8'h00) return int'(x[15:12]);
    if (x[23:16] == 8'hff) return 270 + int'(x[15:12]);
    return 15 + int'(x[23:16]);
  endfunction : region

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic chk_state();
    cmp({12'h000, write_enable_latch_out, scheme_select_bit_out,
         guard_bit_latch_out, prog_fail_out},
        {12'h000, wel_m, scheme_m, latch_m, fail_m});
  endtask : chk_state

  // one frame on the link, then the model follows the same command
  task automatic cmd(input logic [7:0] op, input logic [23:0] x = 0,
                     input logic [63:0] d = 0);
    logic [71:0] f;
    int n, nrd, r;
    bit g;
    f = {64'h0, op};
    n = 8;
    nrd = 0;
    r = region(x);
    g = scheme_m && wel_m;
    case (op)
      OP_PROGRAM_LOCK: begin f = {48'h0, op, d[15:0]}; n = 24; end
      OP_SET_NV_GUARD: begin f = {32'h0, op, 8'h00, x}; n = 40; end
      OP_READ_NV_GUARD, OP_READ_VOL_GUARD: begin
        f = {32'h0, op, 8'h00, x}; n = 40; nrd = 16; end
      OP_WRITE_VOL_GUARD: begin f = {24'h0, op, 8'h00, x, d[7:0]}; n = 48; end
      OP_PASSWORD_UNLOCK: begin f = {op, d}; n = 72; end
      OP_READ_LOCK, OP_READ_LATCH: nrd = 16;
      default: n = 8;
    endcase
    host_serial_model_i.xfer(f, n, nrd, rd);
    case (op)
      OP_WRITE_ENABLE: wel_m = 1'b1;
      OP_SCHEME_SELECT: if (wel_m) scheme_m = 1'b1;
      OP_GANG_LOCK: if (g) vol_m = '{default: 1'b1};
      OP_GANG_UNLOCK: if (g) vol_m = '{default: 1'b0};
      OP_LATCH_CLEAR: if (g) latch_m = 1'b0;
      OP_SET_NV_GUARD: if (g && latch_m) nv_m[r] = 1'b1;
      OP_ERASE_NV_GUARD: if (g && latch_m) nv_m = '{default: 1'b0};
      OP_WRITE_VOL_GUARD: if (g) vol_m[r] = (d[7:0] != 8'h00);
      OP_PROGRAM_LOCK: if (g && lock_m[2:1] == 2'b11) begin
        if (d[2:1] == 2'b00) fail_m = 1'b1;
        else lock_m = lock_m & d[15:0];
      end else if (g) begin
        lock_m = {lock_m[15:3] & d[15:3], lock_m[2:1], lock_m[0] & d[0]};
      end
      OP_PASSWORD_UNLOCK: if (g && !lock_m[2]) begin
        if (d === password_in) latch_m = 1'b1;
        else fail_m = 1'b1;
      end
      OP_READ_LOCK: cmp(rd, lock_m);
      OP_READ_LATCH: cmp(rd, {2{7'h00, latch_m}});
      OP_READ_NV_GUARD: cmp(rd, nv_m[r] ? 16'hffff : 16'h0000);
      OP_READ_VOL_GUARD: cmp(rd, vol_m[r] ? 16'hffff : 16'h0000);
      default: n = 8;
    endcase
    if (nrd == 0 && op != OP_WRITE_ENABLE) wel_m = 1'b0;
  endtask : cmd

  // check port: answer and protection one cycle after the request
  task automatic probe(input logic [23:0] x, input bit p);
    logic [1:0] v;
    int r;
    bit e;
    r = region(x);
    e = scheme_m && (!wp_n_in || nv_m[r] || vol_m[r]);
    @(negedge clk_in);
    chk_valid_in = 1'b1;
    chk_addr_in = x;
    chk_prog_in = p;
    @(negedge clk_in);
    chk_valid_in = 1'b0;
    v = {chk_ack_out, chk_prot_out};
    if (e && p) fail_m = 1'b1;
    @(negedge clk_in);
    cmp({13'h0, v, chk_ack_out}, {13'h0, 1'b1, e, 1'b0});
    chk_state();
  endtask : probe

  task automatic por();
    rst_n_in = 1'b0;
    lock_m = 16'hffff;
    {wel_m, scheme_m, latch_m, fail_m} = 4'h2;
    nv_m = '{default: 1'b0};
    vol_m = '{default: 1'b1};
    repeat (2) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask : por

  // hardware reset pin restores only the volatile state
  task automatic hwr();
    @(negedge clk_in);
    hw_reset_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    hw_reset_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    {wel_m, latch_m, fail_m} = {1'b0, lock_m[2], 1'b0};
    vol_m = '{default: 1'b1};
  endtask : hwr

  task automatic clear_fail();
    @(negedge clk_in);
    prog_ok_in = 1'b1;
    @(negedge clk_in);
    prog_ok_in = 1'b0;
    fail_m = 1'b0;
  endtask : clear_fail

  task automatic done(input string s);
    $display("test %s ended, mismatches so far %0d", s, num_errors);
  endtask : done

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // watchdog sized about 90 us above the expected run of about 240 us
  initial begin
    #330000;
    num_errors++;
    give_verdict();
  end

  // ********************************************************
  // scenarios
  // ********************************************************
  initial begin
    {ce_in, wp_n_in, hw_reset_n_in} = 3'b111;
    {chk_valid_in, chk_prog_in, prog_fail_in, prog_ok_in} = 4'h0;
    chk_addr_in = 24'h000000;
    password_in = {rnd(), rnd()};
    por();
    chk_state(); // power-on values
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GANG_UNLOCK); // ignored without the scheme
    cmd(OP_WRITE_ENABLE);
    cmd(OP_SCHEME_SELECT);
    chk_state(); // scheme now active
    a = 24'(rnd());
    cmd(OP_READ_VOL_GUARD, a); // volatile reset value
    cmd(OP_READ_NV_GUARD, a); // factory zero
    cmd(OP_READ_LATCH); // latch byte
    cmd(OP_READ_LOCK); // factory lock
    done("reset");
    cmd(OP_GANG_UNLOCK); // refused without write enable
    cmd(OP_WRITE_ENABLE);
    host_serial_model_i.xfer({63'h0, OP_GANG_UNLOCK, 1'b0}, 9, 0, rd);
    wel_m = 1'b0;
    probe(a, 1'b0); // odd length rejected
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GANG_UNLOCK);
    for (int i = 0; i < 3; i++) probe(24'(rnd()), 1'b1); // all clear
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GANG_LOCK);
    probe(24'(rnd()), 1'b0); // all set
    done("gang");
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GANG_UNLOCK);
    // walk the four guard combinations at edge and middle regions
    for (int i = 0; i < 4; i++) begin
      a = 24'(rnd());
      if (i == 0) a[23:16] = 8'h00;
      if (i == 3) a[23:16] = 8'hff;
      cmd(OP_WRITE_ENABLE);
      cmd(OP_ERASE_NV_GUARD); // erase all
      cmd(OP_WRITE_ENABLE);
      cmd(OP_WRITE_VOL_GUARD, a, i[0] ? 64'(rnd() | 1) : 64'h0);
      if (i[1]) cmd(OP_WRITE_ENABLE);
      if (i[1]) cmd(OP_SET_NV_GUARD, a); // single set
      probe(a, 1'b1); // combined guard
      probe(a ^ 24'h000fff, 1'b0); // same region
      probe(a ^ 24'h001000, 1'b1); // next sector
      clear_fail();
    end
    a3 = a;
    cmd(OP_READ_NV_GUARD, a3); // set entry
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GANG_UNLOCK);
    wp_n_in = 1'b0;
    repeat (4) @(negedge clk_in);
    probe(24'(rnd()), 1'b0); // pin protects all
    wp_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    @(negedge clk_in);
    prog_fail_in = 1'b1;
    @(negedge clk_in);
    prog_fail_in = 1'b0;
    fail_m = 1'b1;
    @(negedge clk_in);
    chk_state(); // array failure
    clear_fail();
    done("guards");
    cmd(OP_WRITE_ENABLE);
    cmd(OP_LATCH_CLEAR);
    chk_state(); // latch cleared
    cmd(OP_WRITE_ENABLE);
    cmd(OP_ERASE_NV_GUARD);
    cmd(OP_READ_NV_GUARD, a3); // erase ignored
    hwr();
    chk_state(); // only reset restores latch
    cmd(OP_WRITE_ENABLE);
    cmd(OP_GANG_UNLOCK);
    probe(a3, 1'b0); // guard kept over reset
    done("latch");
    cmd(OP_WRITE_ENABLE);
    cmd(OP_PROGRAM_LOCK, 24'h0, 64'hfffd); // solid fixed
    cmd(OP_WRITE_ENABLE);
    cmd(OP_PROGRAM_LOCK, 24'h0, 64'hfffb); // other bit kept
    cmd(OP_READ_LOCK); // lock value
    done("solid");
    por();
    cmd(OP_WRITE_ENABLE);
    cmd(OP_SCHEME_SELECT);
    cmd(OP_WRITE_ENABLE);
    cmd(OP_PROGRAM_LOCK, 24'h0, 64'hfff9);
    chk_state(); // both bits aborted, flag set
    cmd(OP_READ_LOCK); // unchanged lock
    cmd(OP_WRITE_ENABLE); // password already stored beforehand
    cmd(OP_PROGRAM_LOCK, 24'h0, 64'hfffb); // password fixed
    hwr();
    cmd(OP_READ_LATCH); // locked after reset
    a = 24'(rnd());
    cmd(OP_WRITE_ENABLE);
    cmd(OP_SET_NV_GUARD, a);
    cmd(OP_READ_NV_GUARD, a); // latch zero ignores set
    cmd(OP_WRITE_ENABLE);
    cmd(OP_PASSWORD_UNLOCK, 24'h0, ~password_in);
    chk_state(); // wrong password
    clear_fail();
    cmd(OP_WRITE_ENABLE);
    cmd(OP_PASSWORD_UNLOCK, 24'h0, password_in);
    chk_state(); // valid password opens latch
    cmd(OP_WRITE_ENABLE);
    cmd(OP_SET_NV_GUARD, a);
    cmd(OP_READ_NV_GUARD, a); // set after unlock
    done("password");
    give_verdict();
  end
endmodule : testbench
